// ### shared/bcs_map.vh
// constants shared by the battery charge sequencer files
`ifndef BCS_MAP_VH
`define BCS_MAP_VH

// ----------------------------------------------------------------
// clock and time units
// ----------------------------------------------------------------
`define BCS_CLK_MHZ 25
`define BCS_NS_PER_US 1000
`define BCS_US_PER_MS 1000
`define BCS_TICK_MS 1000
`define BCS_SEC_PER_MIN 60
`define BCS_SOFT_MIN 5
`define BCS_QUAL_MIN 1
`define BCS_TOP_BASE_S 1200
`define BCS_BEEP_S 4'h1
`define BCS_RC_DIS_NS 10000
`define BCS_SETTLE_NS 2000
`define BCS_FAST_PWM_US 4000
`define BCS_SLOW_PWM_MS 10000
`define BCS_REPORT_BIT_MS 100
`define BCS_PWM_STEPS 256
`define BCS_REPORT_BITS 5'h10

// ----------------------------------------------------------------
// apb register map
// ----------------------------------------------------------------
`define BCS_OFF_CTRL 8'h00
`define BCS_OFF_STATUS 8'h04
`define BCS_OFF_TIMEOUT 8'h08
`define BCS_OFF_MEAS 8'h0C
`define BCS_CTRL_RESET 2'h3
`define BCS_CTRL_CHG_EN 0
`define BCS_CTRL_BUZ_EN 1

// ----------------------------------------------------------------
// strap levels and analog thresholds (10-bit codes, 5 V full scale)
// ----------------------------------------------------------------
`define BCS_LVL_LOW 2'h0
`define BCS_LVL_HIGH 2'h1
`define BCS_LVL_OPEN 2'h2
`define BCS_V_NI_MAX 10'h26A
`define BCS_V_GOOD 10'h0F6
`define BCS_V_PRESENT 10'h0CD
`define BCS_V_DISCHARGED 10'h15C
`define BCS_V_LI_41 10'h224
`define BCS_V_LI_42 10'h231
`define BCS_V_LI_RESTART 10'h1B9
`define BCS_CS_LOW_RATE 10'h1D7
`define BCS_CS_FAST 10'h133
`define BCS_CS_MAINT 10'h1F6
`define BCS_T_LOW 10'h066
`define BCS_T_START 10'h1C3
`define BCS_DROP_NICD 10'h00A
`define BCS_DROP_NIMH 10'h004

// ----------------------------------------------------------------
// slow-mode duties
// ----------------------------------------------------------------
`define BCS_DUTY_FULL 8'hFF
`define BCS_DUTY_LOW 8'h33
`define BCS_DUTY_MAINT 8'h0D

`endif

// ### rtl/bcs_pwm.v
// charge-control output generator, fast pwm or slow on/off
`timescale 1ns/100ps
`include "bcs_map.vh"
module bcs_pwm #(
	parameter [19:0] FAST_STEP = 20'h00186,
	parameter [19:0] SLOW_STEP = 20'hEE6B2
) (
	input wire i_clk,
	input wire i_rst,
	input wire i_ce,
	input wire i_enable,
	input wire i_fast,
	input wire [7:0] i_duty,
	output reg o_out
);
	reg [19:0] pre;
	reg [7:0] phase;
	wire [19:0] limit = i_fast ? (FAST_STEP - 20'h00001) : (SLOW_STEP - 20'h00001);

	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pre <= 20'h00000;
			phase <= 8'h00;
			o_out <= 1'b0;
		end else if (i_ce) begin
			if (!i_enable) begin
				pre <= 20'h00000;
				phase <= 8'h00;
				o_out <= 1'b0;
			end else begin
				if (pre >= limit) begin
					pre <= 20'h00000;
					phase <= phase + 8'h01;
				end else begin
					pre <= pre + 20'h00001;
				end
				// full duty stays on with no notch at wrap
				o_out <= (i_duty == `BCS_DUTY_FULL) | (phase < i_duty);
			end
		end
	end
endmodule

// ### rtl/bcs_tristrap.v
// tri-level strap reader using a switched weak pull
`timescale 1ns/100ps
`include "bcs_map.vh"
module bcs_tristrap #(
	parameter [7:0] SETTLE = 8'h32
) (
	input wire i_clk,
	input wire i_rst,
	input wire i_ce,
	input wire i_start,
	input wire i_pin,
	output reg o_pull_up,
	output reg o_done,
	output reg [1:0] o_level
);
	localparam [1:0] S_IDLE = 2'h0;
	localparam [1:0] S_UP = 2'h1;
	localparam [1:0] S_DOWN = 2'h2;
	reg [1:0] st;
	reg [7:0] cnt;
	reg up_val;

	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st <= S_IDLE;
			cnt <= 8'h00;
			up_val <= 1'b0;
			o_pull_up <= 1'b0;
			o_done <= 1'b0;
			o_level <= `BCS_LVL_LOW;
		end else if (i_ce) begin
			o_done <= 1'b0;
			case (st)
				S_IDLE: begin
					cnt <= 8'h00;
					if (i_start) begin
						o_pull_up <= 1'b1;
						st <= S_UP;
					end
				end
				S_UP: begin
					cnt <= cnt + 8'h01;
					if (cnt == SETTLE) begin
						up_val <= i_pin;
						o_pull_up <= 1'b0;
						cnt <= 8'h00;
						st <= S_DOWN;
					end
				end
				S_DOWN: begin
					cnt <= cnt + 8'h01;
					if (cnt == SETTLE) begin
						// a pin that follows the pull is floating
						if (up_val && !i_pin) begin
							o_level <= `BCS_LVL_OPEN;
						end else if (i_pin) begin
							o_level <= `BCS_LVL_HIGH;
						end else begin
							o_level <= `BCS_LVL_LOW;
						end
						o_done <= 1'b1;
						st <= S_IDLE;
					end
				end
				default: begin
					st <= S_IDLE;
				end
			endcase
		end
	end
endmodule

// ### rtl/bcs_charge_sequencer.v
// battery charge sequencer top: phase machine, indicators, apb registers
`timescale 1ns/100ps
`include "bcs_map.vh"
// Notes on behaviour
// (R1) nickel soft start 0.2C, five minutes
// (R2) soft start errors on overvoltage or weak battery
// (R3) temperature window checked before charging
// (R4) nickel fast ends on voltage fall from peak
// (R5) nickel fast errors on over-temperature
// (R6) topping 0.2C for RC-set time
// (R7) maintenance fixed fraction; nickel pre-discharge optional
// (R8) lithium qualification one minute, low voltage errors
// (R9) lithium constant current until strap-chosen voltage
// (R10) lithium constant voltage until current falls
// (R11) nickel discharge/maintenance strap meaning
// (R12) lithium maintenance and restart strap meaning
// (R13) chemistry strap chooses battery type
// (R14) nickel supply strap selects fast or slow output
// (R15) lithium supply strap selects cell voltage
// (R16) lithium always uses current feedback
// (R17) phase indicator active low, drives timeout RC
// (R18) charge indicator active low, reports straps serially
// (R19) start/stop/error indicator active low
// (R20) discharge drive high only while pre-discharging
// (R21) health pin pulled low on illegal state
// (R22) buzzer is a plain level
// (R23) slow output on/off, fast output pwm
// (R24) active-low reset pin restarts sequence
// (R25) RC timeout backs up fast phases, times topping
// (R26) error held until removal or temperature recovery
// (R27) straps sampled once after reset before charging
module bcs_charge_sequencer #(
	parameter ADDR_W = 8,
	parameter TICK_CYCLES = `BCS_TICK_MS * `BCS_CLK_MHZ * `BCS_US_PER_MS,
	parameter SLOW_STEP_CYCLES = `BCS_SLOW_PWM_MS * `BCS_CLK_MHZ * `BCS_US_PER_MS
		/ `BCS_PWM_STEPS,
	parameter REPORT_BIT_CYCLES = `BCS_REPORT_BIT_MS * `BCS_CLK_MHZ * `BCS_US_PER_MS
) (
	input wire I_CLK,
	input wire I_RST,
	input wire I_CE,
	input wire I_RESET_N,
	input wire I_PSEL,
	input wire I_PENABLE,
	input wire I_PWRITE,
	input wire [ADDR_W-1:0] I_PADDR,
	input wire [31:0] I_PWDATA,
	output reg [31:0] O_PRDATA,
	output wire O_PREADY,
	output wire O_PSLVERR,
	input wire I_SAMPLE_VALID,
	input wire [9:0] I_BATTERY_VOLTAGE_INPUT,
	input wire [9:0] I_CURRENT_SENSE,
	input wire [9:0] I_TEMPERATURE,
	input wire I_DISCHARGE_MAINT_SELECT,
	output wire O_DISCHARGE_MAINT_SELECT_PULLUP,
	input wire I_CHEMISTRY_SELECT,
	output wire O_CHEMISTRY_SELECT_PULLUP,
	input wire I_SUPPLY_OR_CELL_SELECT,
	input wire I_TIMEOUT_RC_INPUT,
	output wire O_CHARGE_CONTROL,
	output reg O_DISCHARGE_DRIVE,
	output reg O_BUZZER,
	output reg O_PHASE_INDICATOR_N,
	output reg O_CHARGE_DISCHARGE_INDICATOR_N,
	output reg O_START_STOP_ERROR_INDICATOR_N,
	output wire O_HEALTH_MONITOR_OUT_O,
	output reg O_HEALTH_MONITOR_OUT_OE
);
	// ----------------------------------------------------------------
	// states and derived counts
	// ----------------------------------------------------------------
	localparam [3:0] ST_STRAP = 4'h0;
	localparam [3:0] ST_RC = 4'h1;
	localparam [3:0] ST_REPORT = 4'h2;
	localparam [3:0] ST_WAIT_BAT = 4'h3;
	localparam [3:0] ST_TCHECK = 4'h4;
	localparam [3:0] ST_DISCH = 4'h5;
	localparam [3:0] ST_SOFT = 4'h6;
	localparam [3:0] ST_FAST = 4'h7;
	localparam [3:0] ST_TOP = 4'h8;
	localparam [3:0] ST_MAINT = 4'h9;
	localparam [3:0] ST_QUAL = 4'hA;
	localparam [3:0] ST_LI_CC = 4'hB;
	localparam [3:0] ST_LI_CV = 4'hC;
	localparam [3:0] ST_DONE = 4'hD;
	localparam [3:0] ST_ERROR = 4'hE;

	localparam [31:0] TICK_LAST = TICK_CYCLES - 1;
	localparam [31:0] BIT_LAST = REPORT_BIT_CYCLES - 1;
	localparam [31:0] FAST_STEP = `BCS_FAST_PWM_US * `BCS_CLK_MHZ / `BCS_PWM_STEPS;
	localparam [31:0] SLOW_STEP = SLOW_STEP_CYCLES;
	localparam [31:0] RC_DIS_LAST = (`BCS_RC_DIS_NS * `BCS_CLK_MHZ + `BCS_NS_PER_US - 1)
		/ `BCS_NS_PER_US - 1;
	localparam [31:0] SETTLE_CYC = (`BCS_SETTLE_NS * `BCS_CLK_MHZ + `BCS_NS_PER_US - 1)
		/ `BCS_NS_PER_US;
	localparam [31:0] SOFT_TICKS = `BCS_SOFT_MIN * `BCS_SEC_PER_MIN;
	localparam [31:0] QUAL_TICKS = `BCS_QUAL_MIN * `BCS_SEC_PER_MIN;
	localparam [31:0] TOP_BASE = `BCS_TOP_BASE_S;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function removed;
		input [9:0] v;
		begin
			removed = (v <= `BCS_V_PRESENT);
		end
	endfunction

	function is_charging;
		input [3:0] s;
		begin
			is_charging = (s == ST_SOFT) | (s == ST_FAST) | (s == ST_TOP) | (s == ST_MAINT)
				| (s == ST_QUAL) | (s == ST_LI_CC) | (s == ST_LI_CV);
		end
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	reg [3:0] state;
	reg [3:0] prev_state;
	reg [31:0] tick_cnt;
	reg tick;
	reg [31:0] ph_ticks;
	reg [31:0] cnt;
	reg rc_dis;
	reg [19:0] rc_count;
	reg [15:0] report;
	reg [4:0] bits_left;
	reg [1:0] chem;
	reg [1:0] dm;
	reg sc;
	reg [9:0] peak;
	reg [7:0] duty;
	reg [3:0] beep_cnt;
	reg err_temp;
	reg [1:0] ctrl;
	reg [9:0] vbat_r;
	reg [9:0] cs_r;

	wire dm_done;
	wire chem_done;
	wire [1:0] dm_lvl;
	wire [1:0] chem_lvl;
	wire [9:0] vbat = I_BATTERY_VOLTAGE_INPUT;
	wire li = (chem == `BCS_LVL_OPEN);
	wire fast_mode = li | sc; // [R14] [R16]
	wire [9:0] li_vmax = sc ? `BCS_V_LI_42 : `BCS_V_LI_41; // [R15]
	wire [9:0] drop = (chem == `BCS_LVL_HIGH) ? `BCS_DROP_NIMH : `BCS_DROP_NICD;
	wire [10:0] fall = {1'b0, peak} - {1'b0, vbat};
	wire fell = !fall[10] && (fall[9:0] >= drop);
	wire temp_ok = (I_TEMPERATURE > `BCS_T_LOW) && (I_TEMPERATURE < `BCS_T_START);
	wire over_temp = (I_TEMPERATURE <= `BCS_T_LOW);
	wire [31:0] top_ticks = TOP_BASE + {20'h00000, rc_count[19:8]};
	wire [31:0] fast_ticks = {top_ticks[29:0], 2'b00};
	wire chg_en = ctrl[`BCS_CTRL_CHG_EN];
	wire smp = I_SAMPLE_VALID;

	// ----------------------------------------------------------------
	// strap readers and charge-control output
	// ----------------------------------------------------------------
	bcs_tristrap #(.SETTLE(SETTLE_CYC[7:0])) u_dm_strap (
		.i_clk(I_CLK),
		.i_rst(I_RST),
		.i_ce(I_CE),
		.i_start(state == ST_STRAP),
		.i_pin(I_DISCHARGE_MAINT_SELECT),
		.o_pull_up(O_DISCHARGE_MAINT_SELECT_PULLUP),
		.o_done(dm_done),
		.o_level(dm_lvl)
	);

	bcs_tristrap #(.SETTLE(SETTLE_CYC[7:0])) u_chem_strap (
		.i_clk(I_CLK),
		.i_rst(I_RST),
		.i_ce(I_CE),
		.i_start(state == ST_STRAP),
		.i_pin(I_CHEMISTRY_SELECT),
		.o_pull_up(O_CHEMISTRY_SELECT_PULLUP),
		.o_done(chem_done),
		.o_level(chem_lvl)
	);

	reg [7:0] pwm_duty;
	always @* begin
		// slow mode cannot regulate, so the fraction is a fixed on/off ratio
		if (fast_mode) begin
			pwm_duty = duty;
		end else if (state == ST_FAST) begin
			pwm_duty = `BCS_DUTY_FULL;
		end else if (state == ST_MAINT) begin
			pwm_duty = `BCS_DUTY_MAINT; // [R7]
		end else begin
			pwm_duty = `BCS_DUTY_LOW;
		end
	end

	bcs_pwm #(.FAST_STEP(FAST_STEP[19:0]), .SLOW_STEP(SLOW_STEP[19:0])) u_pwm (
		.i_clk(I_CLK),
		.i_rst(I_RST),
		.i_ce(I_CE),
		.i_enable(is_charging(state)),
		.i_fast(fast_mode),
		.i_duty(pwm_duty),
		.o_out(O_CHARGE_CONTROL) // [R23]
	);

	// ----------------------------------------------------------------
	// one-second tick
	// ----------------------------------------------------------------
	always @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			tick_cnt <= 32'h00000000;
			tick <= 1'b0;
		end else if (I_CE) begin
			tick <= (tick_cnt == TICK_LAST);
			if (tick_cnt == TICK_LAST) begin
				tick_cnt <= 32'h00000000;
			end else begin
				tick_cnt <= tick_cnt + 32'h00000001;
			end
		end
	end

	// ----------------------------------------------------------------
	// phase sequencer
	// ----------------------------------------------------------------
	always @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			state <= ST_STRAP;
			prev_state <= ST_STRAP;
			ph_ticks <= 32'h00000000;
			cnt <= 32'h00000000;
			rc_dis <= 1'b1;
			rc_count <= 20'h00000;
			report <= 16'h0000;
			bits_left <= 5'h00;
			chem <= `BCS_LVL_LOW;
			dm <= `BCS_LVL_LOW;
			sc <= 1'b0;
			peak <= 10'h000;
			beep_cnt <= 4'h0;
			err_temp <= 1'b0;
			O_HEALTH_MONITOR_OUT_OE <= 1'b0;
		end else if (I_CE) begin
			prev_state <= state;
			if (state != prev_state) begin
				ph_ticks <= 32'h00000000;
			end else if (tick) begin
				ph_ticks <= ph_ticks + 32'h00000001;
			end
			if (tick && beep_cnt != 4'h0) begin
				beep_cnt <= beep_cnt - 4'h1;
			end
			if (!I_RESET_N) begin
				state <= ST_STRAP; // [R24]
				err_temp <= 1'b0;
			end else begin
				case (state)
					ST_STRAP: begin
						if (dm_done && chem_done) begin
							dm <= dm_lvl; // [R27] [R11] [R12]
							chem <= chem_lvl; // [R13]
							sc <= I_SUPPLY_OR_CELL_SELECT;
							cnt <= 32'h00000000;
							rc_dis <= 1'b1;
							state <= ST_RC;
						end
					end
					ST_RC: begin
						// empty the timing cap, then time its charge to threshold
						cnt <= cnt + 32'h00000001;
						if (rc_dis) begin
							if (cnt[19:0] == RC_DIS_LAST[19:0]) begin
								rc_dis <= 1'b0;
								cnt <= 32'h00000000;
							end
						end else if (I_TIMEOUT_RC_INPUT || (&cnt[19:0])) begin
							rc_count <= cnt[19:0]; // [R25]
							report <= {chem, dm, sc, cnt[19:9]}; // [R18]
							bits_left <= `BCS_REPORT_BITS;
							cnt <= 32'h00000000;
							state <= ST_REPORT;
						end
					end
					ST_REPORT: begin
						cnt <= cnt + 32'h00000001;
						if (cnt == BIT_LAST) begin
							cnt <= 32'h00000000;
							report <= {report[14:0], 1'b0};
							bits_left <= bits_left - 5'h01;
							if (bits_left == 5'h01) begin
								state <= ST_WAIT_BAT;
							end
						end
					end
					ST_WAIT_BAT: begin
						if (smp && chg_en && !removed(vbat)) begin
							state <= ST_TCHECK;
						end
					end
					ST_TCHECK: begin
						if (smp) begin
							if (removed(vbat)) begin
								state <= ST_WAIT_BAT;
							end else if (!temp_ok) begin
								err_temp <= 1'b1; // [R3]
								beep_cnt <= `BCS_BEEP_S;
								state <= ST_ERROR;
							end else begin
								beep_cnt <= `BCS_BEEP_S;
								err_temp <= 1'b0;
								if (li) begin
									state <= ST_QUAL;
								end else if (dm == `BCS_LVL_OPEN) begin
									state <= ST_DISCH; // [R11]
								end else if (dm == `BCS_LVL_LOW) begin
									state <= ST_MAINT;
								end else begin
									state <= ST_SOFT;
								end
							end
						end
					end
					ST_DISCH: begin
						if (smp && removed(vbat)) begin
							state <= ST_WAIT_BAT;
						end else if (smp && vbat < `BCS_V_DISCHARGED) begin
							state <= ST_SOFT; // [R7]
						end
					end
					ST_SOFT: begin
						if (smp && removed(vbat)) begin
							state <= ST_WAIT_BAT;
						end else if (smp && vbat > `BCS_V_NI_MAX) begin
							beep_cnt <= `BCS_BEEP_S;
							state <= ST_ERROR; // [R2]
						end else if (smp && ph_ticks >= SOFT_TICKS) begin
							if (vbat < `BCS_V_GOOD) begin
								beep_cnt <= `BCS_BEEP_S;
								state <= ST_ERROR; // [R2]
							end else begin
								peak <= vbat;
								state <= ST_FAST; // [R1]
							end
						end
					end
					ST_FAST: begin
						if (smp) begin
							if (vbat > peak) begin
								peak <= vbat;
							end
							if (removed(vbat)) begin
								state <= ST_WAIT_BAT;
							end else if (over_temp) begin
								err_temp <= 1'b1; // [R5]
								beep_cnt <= `BCS_BEEP_S;
								state <= ST_ERROR;
							end else if (vbat > `BCS_V_NI_MAX || ph_ticks >= fast_ticks) begin
								beep_cnt <= `BCS_BEEP_S; // [R25]
								state <= ST_ERROR;
							end else if (fell) begin
								state <= ST_TOP; // [R4]
							end
						end
					end
					ST_TOP: begin
						if (smp && removed(vbat)) begin
							state <= ST_WAIT_BAT;
						end else if (ph_ticks >= top_ticks) begin
							beep_cnt <= `BCS_BEEP_S;
							state <= ST_MAINT; // [R6] [R25]
						end
					end
					ST_MAINT: begin
						if (smp && removed(vbat)) begin
							state <= ST_WAIT_BAT;
						end else if (smp && li && dm == `BCS_LVL_LOW
							&& vbat < `BCS_V_LI_RESTART) begin
							state <= ST_LI_CC; // [R12]
						end
					end
					ST_QUAL: begin
						if (smp && removed(vbat)) begin
							state <= ST_WAIT_BAT;
						end else if (smp && ph_ticks >= QUAL_TICKS) begin
							beep_cnt <= (vbat < `BCS_V_GOOD) ? `BCS_BEEP_S : beep_cnt;
							state <= (vbat < `BCS_V_GOOD) ? ST_ERROR : ST_LI_CC; // [R8]
						end
					end
					ST_LI_CC: begin
						if (smp && removed(vbat)) begin
							state <= ST_WAIT_BAT;
						end else if (smp && vbat >= li_vmax) begin
							state <= ST_LI_CV; // [R9]
						end else if (ph_ticks >= fast_ticks) begin
							beep_cnt <= `BCS_BEEP_S;
							state <= ST_ERROR;
						end
					end
					ST_LI_CV: begin
						if (smp && removed(vbat)) begin
							state <= ST_WAIT_BAT;
						end else if (smp && I_CURRENT_SENSE > `BCS_CS_LOW_RATE) begin
							beep_cnt <= `BCS_BEEP_S;
							state <= (dm == `BCS_LVL_OPEN) ? ST_DONE : ST_MAINT; // [R10] [R12]
						end else if (ph_ticks >= fast_ticks) begin
							beep_cnt <= `BCS_BEEP_S;
							state <= ST_ERROR;
						end
					end
					ST_DONE: begin
						if (smp && removed(vbat)) begin
							state <= ST_WAIT_BAT;
						end else if (smp && vbat < `BCS_V_LI_RESTART) begin
							state <= ST_LI_CC; // [R12]
						end
					end
					ST_ERROR: begin
						if (smp && removed(vbat)) begin
							err_temp <= 1'b0;
							state <= ST_WAIT_BAT; // [R26]
						end else if (smp && err_temp && temp_ok) begin
							state <= ST_TCHECK; // [R26]
						end
					end
					default: begin
						O_HEALTH_MONITOR_OUT_OE <= 1'b1; // [R21]
						state <= ST_STRAP;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// current loop and outputs
	// ----------------------------------------------------------------
	reg [9:0] cs_target;
	always @* begin
		if (state == ST_FAST || state == ST_LI_CC || state == ST_LI_CV) begin
			cs_target = `BCS_CS_FAST;
		end else if (state == ST_MAINT) begin
			cs_target = `BCS_CS_MAINT; // [R7]
		end else begin
			cs_target = `BCS_CS_LOW_RATE; // [R1] [R6] [R8]
		end
	end

	always @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			duty <= 8'h00;
			vbat_r <= 10'h000;
			cs_r <= 10'h000;
			O_DISCHARGE_DRIVE <= 1'b0;
			O_BUZZER <= 1'b0;
			O_PHASE_INDICATOR_N <= 1'b1;
			O_CHARGE_DISCHARGE_INDICATOR_N <= 1'b1;
			O_START_STOP_ERROR_INDICATOR_N <= 1'b1;
		end else if (I_CE) begin
			if (smp) begin
				vbat_r <= vbat;
				cs_r <= I_CURRENT_SENSE;
			end
			// sense is inverted: a higher code means less current
			if (!is_charging(state)) begin
				duty <= 8'h00;
			end else if (smp) begin
				if (state == ST_LI_CV && vbat > li_vmax) begin
					duty <= (duty != 8'h00) ? duty - 8'h01 : duty; // [R10]
				end else if (I_CURRENT_SENSE > cs_target && duty != 8'hFF) begin
					duty <= duty + 8'h01;
				end else if (I_CURRENT_SENSE < cs_target && duty != 8'h00) begin
					duty <= duty - 8'h01;
				end
			end
			O_DISCHARGE_DRIVE <= (state == ST_DISCH); // [R20]
			O_BUZZER <= (beep_cnt != 4'h0) & ctrl[`BCS_CTRL_BUZ_EN]; // [R22]
			if (state == ST_RC) begin
				O_PHASE_INDICATOR_N <= !rc_dis; // [R17]
			end else begin
				O_PHASE_INDICATOR_N <= !(state == ST_FAST || state == ST_TOP
					|| state == ST_LI_CC || state == ST_LI_CV); // [R17]
			end
			if (state == ST_REPORT) begin
				O_CHARGE_DISCHARGE_INDICATOR_N <= !report[15]; // [R18]
			end else begin
				O_CHARGE_DISCHARGE_INDICATOR_N <= !(is_charging(state) || state == ST_DISCH);
			end
			O_START_STOP_ERROR_INDICATOR_N <= !(state == ST_ERROR || beep_cnt != 4'h0); // [R19]
		end
	end

	assign O_HEALTH_MONITOR_OUT_O = 1'b0;

	// ----------------------------------------------------------------
	// apb slave, zero wait states
	// ----------------------------------------------------------------
	wire [7:0] off = I_PADDR[7:0];
	wire hit = (off == `BCS_OFF_CTRL) || (off == `BCS_OFF_STATUS)
		|| (off == `BCS_OFF_TIMEOUT) || (off == `BCS_OFF_MEAS);
	assign O_PREADY = I_PSEL & I_PENABLE;
	assign O_PSLVERR = I_PSEL & I_PENABLE & !hit;

	always @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			ctrl <= `BCS_CTRL_RESET;
			O_PRDATA <= 32'h00000000;
		end else if (I_CE) begin
			if (I_PSEL && I_PENABLE && I_PWRITE && off == `BCS_OFF_CTRL) begin
				ctrl <= I_PWDATA[1:0];
			end
			if (I_PSEL && !I_PENABLE) begin
				case (off)
					`BCS_OFF_CTRL: O_PRDATA <= {30'h00000000, ctrl};
					`BCS_OFF_STATUS: O_PRDATA <= {19'h00000, O_HEALTH_MONITOR_OUT_OE, fast_mode,
						sc, dm, chem, err_temp, (state == ST_ERROR), state};
					`BCS_OFF_TIMEOUT: O_PRDATA <= {12'h000, rc_count};
					`BCS_OFF_MEAS: O_PRDATA <= {12'h000, cs_r, vbat_r};
					default: O_PRDATA <= 32'h00000000;
				endcase
			end
		end
	end
endmodule

// ### dv/bcs_monitor.sv
// port assertions for the charge sequencer
`timescale 1ns/100ps
module bcs_monitor (
	input wire I_CLK,
	input wire I_RST,
	input wire I_RESET_N,
	input wire I_PSEL,
	input wire I_PENABLE,
	input wire O_PREADY,
	input wire O_CHEMISTRY_SELECT_PULLUP,
	input wire O_PHASE_INDICATOR_N,
	input wire O_CHARGE_DISCHARGE_INDICATOR_N,
	input wire O_START_STOP_ERROR_INDICATOR_N,
	input wire O_DISCHARGE_DRIVE,
	input wire O_CHARGE_CONTROL,
	input wire O_BUZZER,
	input wire O_HEALTH_MONITOR_OUT_O
);
	default clocking cb @(posedge I_CLK);
	endclocking
	// a held restart reruns the strap reads, so checks pause during it
	default disable iff (I_RST || !I_RESET_N);
	sequence s_pull_up;
		O_CHEMISTRY_SELECT_PULLUP [*8];
	endsequence
	sequence s_rc_sink;
		!O_PHASE_INDICATOR_N [*8];
	endsequence
	a_ready_no_wait: assert property (I_PSEL && I_PENABLE |-> O_PREADY)
		else $error("pready low in access phase");
	a_strap_pull: assert property ($rose(O_CHEMISTRY_SELECT_PULLUP) |-> s_pull_up)
		else $error("strap pull-up released early");
	a_rc_sink: assert property ($fell(O_PHASE_INDICATOR_N) |-> s_rc_sink)
		else $error("phase indicator low too briefly");
	a_disch_no_charge: assert property (O_DISCHARGE_DRIVE |-> !O_CHARGE_CONTROL)
		else $error("charging while discharging");
	a_disch_led: assert property ($rose(O_DISCHARGE_DRIVE) |-> ##[0:2]
		!O_CHARGE_DISCHARGE_INDICATOR_N)
		else $error("discharge not shown");
	a_beep_led: assert property ($rose(O_BUZZER) |-> ##[0:2] !O_START_STOP_ERROR_INDICATOR_N)
		else $error("beep without start indicator");
	a_health_drain: assert property (O_HEALTH_MONITOR_OUT_O == 1'b0)
		else $error("health pin drives high");
	a_restart_idle: assert property (@(posedge I_CLK) disable iff (I_RST)
		!I_RESET_N [*3] |-> !O_DISCHARGE_DRIVE && O_CHARGE_DISCHARGE_INDICATOR_N)
		else $error("outputs active during restart");
endmodule
bind bcs_charge_sequencer bcs_monitor mon_u (.*);

// ### dv/bcs_power_model.sv
// board model: strap wiring, timeout rc network, converter strobe
`timescale 1ns/100ps
module bcs_power_model #(
	parameter RC_DLY = 100
) (
	input wire i_clk,
	input wire [1:0] i_dm_cfg,
	input wire [1:0] i_chem_cfg,
	input wire i_dm_pullup,
	input wire i_chem_pullup,
	input wire i_phase_n,
	output wire o_dm_pin,
	output wire o_chem_pin,
	output reg o_rc_high = 1'b0,
	output reg o_sample = 1'b0
);
	reg [7:0] rc_cnt = 8'h00;
	reg [1:0] div = 2'h0;
	// an open strap follows the weak pull
	assign o_dm_pin = i_dm_cfg == 2'h2 ? i_dm_pullup : i_dm_cfg[0];
	assign o_chem_pin = i_chem_cfg == 2'h2 ? i_chem_pullup : i_chem_cfg[0];
	always @(posedge i_clk) begin
		// capacitor stays empty while the indicator pin sinks it
		rc_cnt <= !i_phase_n ? 8'h00 : (rc_cnt == RC_DLY ? rc_cnt : rc_cnt + 8'h01);
		o_rc_high <= i_phase_n && rc_cnt == RC_DLY;
		div <= div + 2'h1;
		o_sample <= div == 2'h3;
	end
endmodule

// ### dv/bcs_tb.sv
// self-checking bench for the battery charge sequencer
`timescale 1ns/100ps
module testbench;
	reg I_CLK = 1'b0;
	reg I_RST = 1'b1;
	reg I_RESET_N = 1'b1;
	reg I_PSEL = 1'b0;
	reg I_PENABLE = 1'b0;
	reg I_PWRITE = 1'b0;
	reg [7:0] I_PADDR = 8'h00;
	reg [31:0] I_PWDATA = 32'h00000000;
	reg [9:0] I_BATTERY_VOLTAGE_INPUT = 10'h000;
	reg [9:0] I_CURRENT_SENSE = 10'h133;
	reg [9:0] I_TEMPERATURE = 10'h100;
	reg I_SUPPLY_OR_CELL_SELECT = 1'b1;
	reg [1:0] dm_cfg = 2'h2;
	reg [1:0] chem_cfg = 2'h2;
	wire I_CE = 1'b1;
	wire I_SAMPLE_VALID, I_DISCHARGE_MAINT_SELECT, I_CHEMISTRY_SELECT, I_TIMEOUT_RC_INPUT;
	wire [31:0] O_PRDATA;
	wire O_PREADY, O_PSLVERR, O_DISCHARGE_MAINT_SELECT_PULLUP, O_CHEMISTRY_SELECT_PULLUP;
	wire O_CHARGE_CONTROL, O_DISCHARGE_DRIVE, O_BUZZER, O_PHASE_INDICATOR_N;
	wire O_CHARGE_DISCHARGE_INDICATOR_N, O_START_STOP_ERROR_INDICATOR_N;
	wire O_HEALTH_MONITOR_OUT_O, O_HEALTH_MONITOR_OUT_OE;
	reg [31:0] rd;
	reg err;
	integer n_errors = 0, total_checks = 0, j;
	always #20 I_CLK = ~I_CLK;
	// short tick and report bit keep timed phases within the run
	bcs_charge_sequencer #(.TICK_CYCLES(20), .SLOW_STEP_CYCLES(2), .REPORT_BIT_CYCLES(4)) dut_u (.*);
	bcs_power_model board_u (.i_clk(I_CLK), .i_dm_cfg(dm_cfg), .i_chem_cfg(chem_cfg),
		.i_dm_pullup(O_DISCHARGE_MAINT_SELECT_PULLUP), .i_chem_pullup(O_CHEMISTRY_SELECT_PULLUP),
		.i_phase_n(O_PHASE_INDICATOR_N), .o_dm_pin(I_DISCHARGE_MAINT_SELECT),
		.o_chem_pin(I_CHEMISTRY_SELECT), .o_rc_high(I_TIMEOUT_RC_INPUT), .o_sample(I_SAMPLE_VALID));
	task chk(input [31:0] got, input [31:0] exp);
		begin
			total_checks = total_checks + 1;
			if (got !== exp) begin
				n_errors = n_errors + 1;
				$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task apb(input w, input [7:0] a, input [31:0] d);
		begin
			@(posedge I_CLK);
			I_PSEL <= 1'b1;
			I_PWRITE <= w;
			I_PADDR <= a;
			I_PWDATA <= d;
			@(posedge I_CLK);
			I_PENABLE <= 1'b1;
			@(posedge I_CLK);
			while (O_PREADY !== 1'b1) @(posedge I_CLK);
			rd = O_PRDATA;
			err = O_PSLVERR;
			I_PSEL <= 1'b0;
			I_PENABLE <= 1'b0;
		end
	endtask
	task wst(input [3:0] s);
		begin
			rd = 32'h0000000F;
			for (j = 0; j < 3000 && rd[3:0] !== s; j = j + 1) apb(1'b0, 8'h04, 32'h0);
			chk(rd[3:0], s);
		end
	endtask
	task drive(input [9:0] v, input [9:0] t);
		begin
			@(posedge I_CLK);
			I_BATTERY_VOLTAGE_INPUT <= v;
			I_TEMPERATURE <= t;
		end
	endtask
	task restart(input [1:0] c, input [1:0] d, input s);
		begin
			drive(10'h000, 10'h100);
			chem_cfg <= c;
			dm_cfg <= d;
			I_SUPPLY_OR_CELL_SELECT <= s;
			I_RESET_N <= 1'b0;
			repeat (3) @(posedge I_CLK);
			I_RESET_N <= 1'b1;
			wst(4'h3);
			chk(rd[10:6], {s, d, c});
		end
	endtask
	task t_regs;
		begin
			apb(1'b0, 8'h00, 32'h0);
			chk(rd, 32'h00000003);
			apb(1'b1, 8'h00, 32'h0);
			apb(1'b0, 8'h00, 32'h0);
			chk(rd, 32'h00000000);
			apb(1'b1, 8'h00, 32'h00000003);
			apb(1'b0, 8'h10, 32'h0);
			chk(rd, 32'h00000000);
			chk(err, 1'b1);
			chk(O_HEALTH_MONITOR_OUT_OE, 1'b0);
			$display("test regs done");
		end
	endtask
	task t_li;
		begin
			restart(2'h2, 2'h2, 1'b1);
			drive(10'h0E0, 10'h100);
			wst(4'hA);
			wst(4'hE);
			chk(O_START_STOP_ERROR_INDICATOR_N, 1'b0);
			drive(10'h000, 10'h100);
			wst(4'h3);
			drive(10'h200, 10'h100);
			wst(4'hB);
			chk(rd[11], 1'b1);
			chk(O_PHASE_INDICATOR_N, 1'b0);
			drive(10'h224, 10'h100);
			repeat (40) @(posedge I_CLK);
			wst(4'hB);
			drive(10'h231, 10'h100);
			wst(4'hC);
			I_CURRENT_SENSE <= 10'h1E0;
			wst(4'hD);
			drive(10'h1B0, 10'h100);
			wst(4'hB);
			I_CURRENT_SENSE <= 10'h133;
			$display("test lithium done");
		end
	endtask
	task t_ni;
		begin
			restart(2'h1, 2'h2, 1'b0);
			drive(10'h200, 10'h050);
			wst(4'hE);
			chk(rd[5], 1'b1);
			drive(10'h200, 10'h100);
			wst(4'h5);
			chk(O_DISCHARGE_DRIVE, 1'b1);
			chk(O_CHARGE_DISCHARGE_INDICATOR_N, 1'b0);
			chk(rd[11], 1'b0);
			drive(10'h150, 10'h100);
			wst(4'h6);
			chk(O_DISCHARGE_DRIVE, 1'b0);
			drive(10'h270, 10'h100);
			wst(4'hE);
			$display("test nickel done");
		end
	endtask
	task t_fast;
		begin
			restart(2'h1, 2'h1, 1'b1);
			drive(10'h200, 10'h100);
			wst(4'h6);
			wst(4'h7);
			chk(O_PHASE_INDICATOR_N, 1'b0);
			drive(10'h1FC, 10'h100);
			wst(4'h8);
			restart(2'h0, 2'h0, 1'b1);
			drive(10'h200, 10'h100);
			wst(4'h9);
			$display("test fast done");
		end
	endtask
	task test_done;
		begin
			$display("checks %0d mismatches %0d", total_checks, n_errors);
			if (n_errors == 0 && total_checks > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask
	initial begin
		repeat (5) @(posedge I_CLK);
		I_RST <= 1'b0;
		t_regs;
		t_li;
		t_ni;
		t_fast;
		test_done;
	end
	initial begin
		#2000000;
		n_errors = n_errors + 1;
		test_done;
	end
endmodule
